// *** tmr_pkg.sv ***
// Shared constants and types for the dual timer/counter block
package tmr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register indexes (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int          APB_AW     = 12;
  localparam int          APB_DW     = 32;
  localparam int          IDX_W      = 10;
  localparam logic [1:0]  WORD_ALIGN = 2'h0;
  localparam logic [9:0]  IDX_CTRL   = 10'h088;
  localparam logic [9:0]  IDX_MODE   = 10'h089;
  localparam logic [9:0]  IDX_T0L    = 10'h08A;
  localparam logic [9:0]  IDX_T1L    = 10'h08B;
  localparam logic [9:0]  IDX_T0H    = 10'h08C;
  localparam logic [9:0]  IDX_T1H    = 10'h08D;
  localparam logic [9:0]  IDX_DIV    = 10'h08E;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          TF1_BIT    = 7;
  localparam int          TR1_BIT    = 6;
  localparam int          TF0_BIT    = 5;
  localparam int          TR0_BIT    = 4;
  localparam int          DIV0_BIT   = 0;
  localparam int          DIV1_BIT   = 1;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [1:0]  RST_DIV    = 2'h0;

  // ----------------------------------------------------------------
  // Tick rates, in system clock periods
  // ----------------------------------------------------------------
  localparam int          DIV_SLOW   = 12;
  localparam int          DIV_FAST   = 4;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_AUTO8 = 2'b10,
    MODE_SPLIT = 2'b11
  } tmr_mode_t;

  typedef struct packed {
    logic      gate;
    logic      src_ext;
    tmr_mode_t mode;
  } tmr_cfg_t;

  typedef struct packed {
    tmr_cfg_t t1;
    tmr_cfg_t t0;
  } tmr_modes_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } tmr_count_t;

  typedef struct packed {
    logic       ovf;
    tmr_count_t cnt;
  } tmr_step_t;

endpackage

// *** tmr_clk_div.sv ***
// Free-running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/10ps
`default_nettype none

module tmr_clk_div #(
  parameter int DIV = 12
) (
  input  wire logic core_clk_in, // System clock
  input  wire logic sys_rst_in,  // Async reset, active high
  output logic      tick_out     // One-cycle enable pulse
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cnt_ff <= '0;
    else if (cnt_ff == LAST)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + CW'(1);
  end

  assign tick_out = (cnt_ff == LAST);

endmodule // tmr_clk_div

`default_nettype wire

// *** tmr_fall_det.sv ***
// Per-clock sampler of a count pin with falling edge pulse
`timescale 1ns/10ps
`default_nettype none

module tmr_fall_det (
  input  wire logic core_clk_in, // System clock
  input  wire logic sys_rst_in,  // Async reset, active high
  input  wire logic pin_in,      // Count pin, synchronous
  output logic      fall_out     // One-cycle falling edge pulse
);

  logic samp_ff;
  logic prev_ff;

  // Reset to high so a pin low at release gives one falling edge pulse
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      samp_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      samp_ff <= pin_in;
      prev_ff <= samp_ff;
    end
  end

  assign fall_out = prev_ff & ~samp_ff;

endmodule // tmr_fall_det

`default_nettype wire

// *** tmr_dual_timer.sv ***
// Two 8-bit-pair timer/counters with APB register access
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module tmr_dual_timer (
  input  wire logic                       core_clk_in,          // Clock
  input  wire logic                       sys_rst_in,           // Reset
  input  wire logic                       psel_in,              // APB sel
  input  wire logic                       penable_in,           // APB en
  input  wire logic                       pwrite_in,            // APB dir
  input  wire logic [tmr_pkg::APB_AW-1:0] paddr_in,             // APB addr
  input  wire logic [tmr_pkg::APB_DW-1:0] pwdata_in,            // APB wdata
  output logic      [tmr_pkg::APB_DW-1:0] prdata_out,           // APB rdata
  output logic                            pready_out,           // APB ready
  output logic                            pslverr_out,          // APB error
  input  wire logic                       timer0_count_pin_in,  // T0 pin
  input  wire logic                       timer1_count_pin_in,  // T1 pin
  input  wire logic                       timer0_gate_pin_in,   // T0 gate
  input  wire logic                       timer1_gate_pin_in,   // T1 gate
  input  wire logic                       timer0_isr_entry_in,  // T0 ISR
  input  wire logic                       timer1_isr_entry_in,  // T1 ISR
  output logic                            timer0_overflow_flag_out, // TF0
  output logic                            timer1_overflow_flag_out  // TF1
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]           timer0_low_byte_ff;
  logic [7:0]           timer0_high_byte_ff;
  logic [7:0]           timer1_low_byte_ff;
  logic [7:0]           timer1_high_byte_ff;
  tmr_pkg::tmr_modes_t  timer_mode_select_ff;
  logic [1:0]           timer_divide_select_ff;
  logic                 timer0_run_ff;
  logic                 timer1_run_ff;
  logic                 timer0_overflow_flag_ff;
  logic                 timer1_overflow_flag_ff;
  logic [31:0]          prdata_ff;
  logic                 pslverr_ff;

  logic                 tick_slow;
  logic                 tick_fast;
  logic                 fall0;
  logic                 fall1;
  logic                 tick0;
  logic                 tick1;
  logic                 src0;
  logic                 src1;
  logic                 gate_ok0;
  logic                 gate_ok1;
  logic                 split;
  logic                 run1;
  logic                 inc0;
  logic                 inc0h;
  logic                 inc1;
  tmr_pkg::tmr_step_t   step0;
  tmr_pkg::tmr_step_t   step1;
  logic [8:0]           nxt_t0h_split;
  logic                 set_tf0;
  logic                 set_tf1;

  logic [tmr_pkg::IDX_W-1:0] idx;
  logic                 aligned;
  logic                 wr_acc;
  logic                 rd_setup;
  logic                 wr_ctrl;
  logic                 wr_mode;
  logic                 wr_t0l;
  logic                 wr_t1l;
  logic                 wr_t0h;
  logic                 wr_t1h;
  logic                 wr_div;
  logic                 hit;
  logic [7:0]           rd_byte;
  logic [7:0]           ctrl_view;

  // ----------------------------------------------------------------
  // Count step for one timer in modes 0 to 3
  // ----------------------------------------------------------------
  function automatic tmr_pkg::tmr_step_t tmr_step(
    input tmr_pkg::tmr_mode_t  mode,
    input tmr_pkg::tmr_count_t cnt
  );
    tmr_pkg::tmr_step_t r;
    logic [5:0]         p6;
    logic [8:0]         w9;
    logic [16:0]        w17;
    r.ovf = 1'b0;
    r.cnt = cnt;
    p6    = '0;
    w9    = '0;
    w17   = '0;
    unique case (mode)
      tmr_pkg::MODE_13BIT:
      begin
        p6 = {1'b0, cnt.lo[4:0]} + 6'h01;
        r.cnt.lo = {cnt.lo[7:5], p6[4:0]};
        if (p6[5])
        begin
          w9       = {1'b0, cnt.hi} + 9'h001;
          r.cnt.hi = w9[7:0];
          r.ovf    = w9[8];
        end
      end
      tmr_pkg::MODE_16BIT:
      begin
        w17   = {1'b0, cnt} + 17'h00001;
        r.cnt = w17[15:0];
        r.ovf = w17[16];
      end
      tmr_pkg::MODE_AUTO8:
      begin
        w9       = {1'b0, cnt.lo} + 9'h001;
        r.ovf    = w9[8];
        r.cnt.lo = w9[8] ? cnt.hi : w9[7:0];
      end
      // low half alone, high half handled apart
      tmr_pkg::MODE_SPLIT:
      begin
        w9       = {1'b0, cnt.lo} + 9'h001;
        r.ovf    = w9[8];
        r.cnt.lo = w9[7:0];
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Tick and edge sources
  // ----------------------------------------------------------------
  // twelve-clock timer tick
  tmr_clk_div #(
    .DIV (tmr_pkg::DIV_SLOW)
  ) u_div_slow (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .tick_out    (tick_slow)
  );

  tmr_clk_div #(
    .DIV (tmr_pkg::DIV_FAST)
  ) u_div_fast (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .tick_out    (tick_fast)
  );

  tmr_fall_det u_pin0 (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .pin_in      (timer0_count_pin_in),
    .fall_out    (fall0)
  );

  tmr_fall_det u_pin1 (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .pin_in      (timer1_count_pin_in),
    .fall_out    (fall1)
  );

  // ----------------------------------------------------------------
  // Count enables
  // ----------------------------------------------------------------
  // divide-select chooses tick rate
  assign tick0 = timer_divide_select_ff[tmr_pkg::DIV0_BIT] ?
                 tick_fast : tick_slow;
  assign tick1 = timer_divide_select_ff[tmr_pkg::DIV1_BIT] ?
                 tick_fast : tick_slow;

  assign src0 = timer_mode_select_ff.t0.src_ext ? fall0 : tick0;
  assign src1 = timer_mode_select_ff.t1.src_ext ? fall1 : tick1;

  assign gate_ok0 = ~timer_mode_select_ff.t0.gate | timer0_gate_pin_in;
  assign gate_ok1 = ~timer_mode_select_ff.t1.gate | timer1_gate_pin_in;

  assign split = (timer_mode_select_ff.t0.mode == tmr_pkg::MODE_SPLIT);

  // Timer 1 loses its run bit to timer 0 while split, so it free-runs
  assign run1 = split ? 1'b1 : timer1_run_ff;

  assign inc0 = timer0_run_ff & gate_ok0 & src0;
  // split high half driven by timer 1 run
  assign inc0h = split & timer1_run_ff & tick0;
  // timer 1 holds in its own mode 3
  assign inc1 = run1 & gate_ok1 & src1 &
                (timer_mode_select_ff.t1.mode != tmr_pkg::MODE_SPLIT);

  assign step0 = tmr_step(timer_mode_select_ff.t0.mode,
                          {timer0_high_byte_ff, timer0_low_byte_ff});
  assign step1 = tmr_step(timer_mode_select_ff.t1.mode,
                          {timer1_high_byte_ff, timer1_low_byte_ff});
  assign nxt_t0h_split = {1'b0, timer0_high_byte_ff} + 9'h001;

  // split high half raises the timer 1 flag
  assign set_tf0 = inc0 & step0.ovf;
  assign set_tf1 = split ? (inc0h & nxt_t0h_split[8])
                         : (inc1 & step1.ovf);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx      = paddr_in[tmr_pkg::APB_AW-1:2];
  assign aligned  = (paddr_in[1:0] == tmr_pkg::WORD_ALIGN);
  assign wr_acc   = psel_in & penable_in & pwrite_in & aligned;
  assign rd_setup = psel_in & ~penable_in;
  assign wr_ctrl  = wr_acc & (idx == tmr_pkg::IDX_CTRL);
  assign wr_mode  = wr_acc & (idx == tmr_pkg::IDX_MODE);
  assign wr_t0l   = wr_acc & (idx == tmr_pkg::IDX_T0L);
  assign wr_t1l   = wr_acc & (idx == tmr_pkg::IDX_T1L);
  assign wr_t0h   = wr_acc & (idx == tmr_pkg::IDX_T0H);
  assign wr_t1h   = wr_acc & (idx == tmr_pkg::IDX_T1H);
  assign wr_div   = wr_acc & (idx == tmr_pkg::IDX_DIV);

  // External interrupt bits live elsewhere and read as zero here
  always_comb
  begin
    ctrl_view = '0;
    ctrl_view[tmr_pkg::TF1_BIT] = timer1_overflow_flag_ff;
    ctrl_view[tmr_pkg::TR1_BIT] = timer1_run_ff;
    ctrl_view[tmr_pkg::TF0_BIT] = timer0_overflow_flag_ff;
    ctrl_view[tmr_pkg::TR0_BIT] = timer0_run_ff;
  end

  always_comb
  begin
    hit     = aligned;
    rd_byte = '0;
    unique case (idx)
      tmr_pkg::IDX_CTRL: rd_byte = ctrl_view;
      tmr_pkg::IDX_MODE: rd_byte = timer_mode_select_ff;
      tmr_pkg::IDX_T0L:  rd_byte = timer0_low_byte_ff;
      tmr_pkg::IDX_T1L:  rd_byte = timer1_low_byte_ff;
      tmr_pkg::IDX_T0H:  rd_byte = timer0_high_byte_ff;
      tmr_pkg::IDX_T1H:  rd_byte = timer1_high_byte_ff;
      tmr_pkg::IDX_DIV:  rd_byte = {6'h00, timer_divide_select_ff};
      default:           hit     = 1'b0;
    endcase
  end

  // Read data captured in setup so it stands through the access phase
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata_ff  <= (hit & ~pwrite_in) ? {24'h000000, rd_byte} : '0;
      pslverr_ff <= ~hit;
    end
  end

  assign prdata_out  = prdata_ff;
  assign pslverr_out = pslverr_ff & psel_in & penable_in;
  assign pready_out  = psel_in & penable_in;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer_mode_select_ff <= tmr_pkg::RST_BYTE;
    else if (wr_mode)
      timer_mode_select_ff <= pwdata_in[7:0];
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer_divide_select_ff <= tmr_pkg::RST_DIV;
    else if (wr_div)
      timer_divide_select_ff <= pwdata_in[1:0];
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      timer0_run_ff <= 1'b0;
      timer1_run_ff <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      timer0_run_ff <= pwdata_in[tmr_pkg::TR0_BIT];
      timer1_run_ff <= pwdata_in[tmr_pkg::TR1_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Overflow flags: a hardware set beats any clear
  // ----------------------------------------------------------------
  // timer 0 flag set, ISR entry clears
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer0_overflow_flag_ff <= 1'b0;
    else if (set_tf0)
      timer0_overflow_flag_ff <= 1'b1;
    else if (timer0_isr_entry_in)
      timer0_overflow_flag_ff <= 1'b0;
    else if (wr_ctrl)
      timer0_overflow_flag_ff <= pwdata_in[tmr_pkg::TF0_BIT];
  end

  // timer 1 flag set, ISR entry clears
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer1_overflow_flag_ff <= 1'b0;
    else if (set_tf1)
      timer1_overflow_flag_ff <= 1'b1;
    else if (timer1_isr_entry_in)
      timer1_overflow_flag_ff <= 1'b0;
    else if (wr_ctrl)
      timer1_overflow_flag_ff <= pwdata_in[tmr_pkg::TF1_BIT];
  end

  assign timer0_overflow_flag_out = timer0_overflow_flag_ff;
  assign timer1_overflow_flag_out = timer1_overflow_flag_ff;

  // ----------------------------------------------------------------
  // Count registers: a bus write beats a count in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer0_low_byte_ff <= tmr_pkg::RST_BYTE;
    else if (wr_t0l)
      timer0_low_byte_ff <= pwdata_in[7:0];
    else if (inc0)
      timer0_low_byte_ff <= step0.cnt.lo;
  end

  // high byte counts alone while split
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer0_high_byte_ff <= tmr_pkg::RST_BYTE;
    else if (wr_t0h)
      timer0_high_byte_ff <= pwdata_in[7:0];
    else if (inc0h)
      timer0_high_byte_ff <= nxt_t0h_split[7:0];
    else if (inc0 & ~split)
      timer0_high_byte_ff <= step0.cnt.hi;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer1_low_byte_ff <= tmr_pkg::RST_BYTE;
    else if (wr_t1l)
      timer1_low_byte_ff <= pwdata_in[7:0];
    else if (inc1)
      timer1_low_byte_ff <= step1.cnt.lo;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timer1_high_byte_ff <= tmr_pkg::RST_BYTE;
    else if (wr_t1h)
      timer1_high_byte_ff <= pwdata_in[7:0];
    else if (inc1)
      timer1_high_byte_ff <= step1.cnt.hi;
  end

endmodule // tmr_dual_timer

`default_nettype wire

// *** tmr_dual_timer_assertions.sv ***
// Concurrent checks on the ports of the dual timer/counter block
`timescale 1ns/10ps
`default_nettype none

module tmr_dual_timer_assertions (
  input wire logic                       core_clk_in,  // Clock
  input wire logic                       sys_rst_in,   // Reset
  input wire logic                       psel_in,      // APB sel
  input wire logic                       penable_in,   // APB en
  input wire logic                       pwrite_in,    // APB dir
  input wire logic [tmr_pkg::APB_AW-1:0] paddr_in,     // APB addr
  input wire logic [tmr_pkg::APB_DW-1:0] pwdata_in,    // APB wdata
  input wire logic [tmr_pkg::APB_DW-1:0] prdata_out,   // APB rdata
  input wire logic                       pready_out,   // APB ready
  input wire logic                       pslverr_out,  // APB error
  input wire logic                       timer0_count_pin_in,  // T0 pin
  input wire logic                       timer1_count_pin_in,  // T1 pin
  input wire logic                       timer0_gate_pin_in,   // T0 gate
  input wire logic                       timer1_gate_pin_in,   // T1 gate
  input wire logic                       timer0_isr_entry_in,  // T0 ISR
  input wire logic                       timer1_isr_entry_in,  // T1 ISR
  input wire logic                       timer0_overflow_flag_out, // Flag
  input wire logic                       timer1_overflow_flag_out  // Flag
);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  localparam logic [11:0] A_CTRL = {tmr_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_MODE = {tmr_pkg::IDX_MODE, 2'h0};
  logic       acc_w;
  logic       mapped_w;
  logic       ctrl_wr_w;
  logic [7:0] mode_ff;
  assign acc_w     = psel_in && penable_in;
  assign ctrl_wr_w = acc_w && pwrite_in && paddr_in == A_CTRL;
  assign mapped_w  = paddr_in[1:0] == 2'h0 &&
                     paddr_in[11:2] >= tmr_pkg::IDX_CTRL &&
                     paddr_in[11:2] <= tmr_pkg::IDX_DIV;
  // Mode byte shadow; hardware never alters it, so reads must match
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      mode_ff <= 8'h00;
    else if (acc_w && pwrite_in && paddr_in == A_MODE)
      mode_ff <= pwdata_in[7:0];
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_ctrl_rd;
    acc_w && !pwrite_in && paddr_in == A_CTRL;
  endsequence
  sequence s_mode_rd;
    acc_w && !pwrite_in && paddr_in == A_MODE;
  endsequence

  a_ready_zero_wait:
    assert property (pready_out == (psel_in && penable_in))
    else $error("pready does not follow the access phase");
  a_err_unmapped:
    assert property (acc_w && !mapped_w |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped:
    assert property (acc_w && mapped_w |-> !pslverr_out)
    else $error("mapped access refused");
  a_rdata_upper_zero:
    assert property (prdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_ctrl_low_zero:
    assert property (s_ctrl_rd |-> prdata_out[3:0] == 4'h0)
    else $error("control low bits not zero");
  a_tf0_fall_cause:
    assert property ($fell(timer0_overflow_flag_out) |->
                     $past(timer0_isr_entry_in) || $past(ctrl_wr_w))
    else $error("timer0 flag dropped without cause");
  a_tf1_fall_cause:
    assert property ($fell(timer1_overflow_flag_out) |->
                     $past(timer1_isr_entry_in) || $past(ctrl_wr_w))
    else $error("timer1 flag dropped without cause");
  a_mode_readback:
    assert property (s_mode_rd |-> prdata_out[7:0] == mode_ff)
    else $error("mode byte read back wrong");
endmodule // tmr_dual_timer_assertions

bind tmr_dual_timer tmr_dual_timer_assertions tmr_dual_timer_assertions_i (
  .core_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .timer0_count_pin_in,
  .timer1_count_pin_in, .timer0_gate_pin_in, .timer1_gate_pin_in,
  .timer0_isr_entry_in, .timer1_isr_entry_in, .timer0_overflow_flag_out,
  .timer1_overflow_flag_out
);

`default_nettype wire

// *** tmr_pin_model.sv ***
// Model of the external count and gate pin drivers
`timescale 1ns/10ps
`default_nettype none

module tmr_pin_model (
  input  wire logic       core_clk_in,   // System clock
  output logic      [1:0] count_pin_out, // Count pins, idle high
  output logic      [1:0] gate_pin_out   // Gate pins
);
  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  initial
  begin
    count_pin_out = 2'h3;
    gate_pin_out  = 2'h0;
  end
  // levels held two clocks, so every one is sampled
  task automatic pulse(input int w, input int n);
    repeat (n)
    begin
      @(posedge core_clk_in);
      count_pin_out[w] <= 1'h0;
      repeat (2) @(posedge core_clk_in);
      count_pin_out[w] <= 1'h1;
      repeat (2) @(posedge core_clk_in);
    end
  endtask
  task automatic set_gate(input int w, input logic v);
    @(posedge core_clk_in);
    gate_pin_out[w] <= v;
  endtask
endmodule // tmr_pin_model

`default_nettype wire

// *** tmr_dual_timer_test.sv ***
// Self-checking testbench for the dual timer/counter block
`timescale 1ns/10ps
`default_nettype none

module tmr_dual_timer_test;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam logic [11:0] A_CTRL = {tmr_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_MODE = {tmr_pkg::IDX_MODE, 2'h0};
  localparam logic [11:0] A_T0L  = {tmr_pkg::IDX_T0L, 2'h0};
  localparam logic [11:0] A_T1L  = {tmr_pkg::IDX_T1L, 2'h0};
  localparam logic [11:0] A_T0H  = {tmr_pkg::IDX_T0H, 2'h0};
  localparam logic [11:0] A_T1H  = {tmr_pkg::IDX_T1H, 2'h0};
  localparam logic [11:0] A_DIV  = {tmr_pkg::IDX_DIV, 2'h0};
  logic            core_clk_in = 1'h0;
  logic            sys_rst_in  = 1'h1;
  logic            psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic     [11:0] paddr = 12'h000;
  logic     [31:0] pwdata = 32'h0, rd;
  logic            err;
  logic      [1:0] isr = 2'h0;
  wire logic [31:0] prdata;
  wire logic       pready, pslverr;
  wire logic [1:0] flag, cpin, gpin;
  int              error_cnt = 0, checked = 0, cycles = 0;

  tmr_dual_timer tmr_dual_timer_i (
    .core_clk_in, .sys_rst_in, .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .timer0_count_pin_in(cpin[0]), .timer1_count_pin_in(cpin[1]),
    .timer0_gate_pin_in(gpin[0]), .timer1_gate_pin_in(gpin[1]),
    .timer0_isr_entry_in(isr[0]), .timer1_isr_entry_in(isr[1]),
    .timer0_overflow_flag_out(flag[0]), .timer1_overflow_flag_out(flag[1]));
  tmr_pin_model tmr_pin_model_i (
    .core_clk_in, .count_pin_out(cpin), .gate_pin_out(gpin));

  always #25 core_clk_in = ~core_clk_in;
  // Ceiling far above the few hundred cycles the tests need
  always @(posedge core_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'h1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_in);
    pen <= 1'h1;
    // Only the bench ceiling ends a wait for ready
    do
    begin
      @(posedge core_clk_in);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0; pen <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic rng(input logic [11:0] a, input int lo, input int hi);
    apb(1'h0, a, 32'h0);
    check({31'h0, rd >= lo && rd <= hi}, 32'h1);
  endtask
  task automatic flag_chk(input logic [1:0] e);
    @(posedge core_clk_in);
    check({30'h0, flag}, {30'h0, e});
  endtask
  task automatic isr_pulse(input int w);
    @(posedge core_clk_in);
    isr[w] <= 1'h1;
    @(posedge core_clk_in);
    isr[w] <= 1'h0;
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'h0;
    for (int i = 0; i < 7; i++)
      rd_chk(A_CTRL + 12'(4 * i), 32'h0);
    apb(1'h0, 12'h23C, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    wr(A_CTRL + 12'h1, 32'hFF);
    check({31'h0, err}, 32'h1);
    rd_chk(A_CTRL, 32'h0);
    // Both timers at /12 then /4; free divider phase allows one extra tick
    for (int f = 0; f < 2; f++)
    begin
      wr(A_DIV, f ? 32'h3 : 32'h0);
      wr(A_MODE, 32'h11);
      wr(A_T0L, 32'h0);
      wr(A_T1L, 32'h0);
      wr(A_CTRL, 32'h50);
      repeat (120) @(posedge core_clk_in);
      wr(A_CTRL, 32'h0);
      rng(A_T0L, f ? 30 : 10, f ? 31 : 11);
      rng(A_T1L, f ? 30 : 10, f ? 31 : 11);
      rd_chk(A_DIV, f ? 32'h3 : 32'h0);
    end
    wr(A_DIV, 32'h0);
    wr(A_MODE, 32'h05);
    wr(A_T0L, 32'h0);
    wr(A_T0H, 32'h0);
    wr(A_CTRL, 32'h10);
    tmr_pin_model_i.pulse(0, 5);
    rd_chk(A_T0L, 32'h05);
    wr(A_CTRL, 32'h0);
    tmr_pin_model_i.pulse(0, 2);
    rd_chk(A_T0L, 32'h05);
    wr(A_MODE, 32'h0D);
    wr(A_CTRL, 32'h10);
    tmr_pin_model_i.pulse(0, 3);
    rd_chk(A_T0L, 32'h05);
    tmr_pin_model_i.set_gate(0, 1'h1);
    tmr_pin_model_i.pulse(0, 2);
    rd_chk(A_T0L, 32'h07);
    tmr_pin_model_i.set_gate(0, 1'h0);
    wr(A_MODE, 32'h05);
    wr(A_T0H, 32'hFF);
    wr(A_T0L, 32'hFE);
    tmr_pin_model_i.pulse(0, 2);
    rd_chk(A_T0L, 32'h0);
    rd_chk(A_T0H, 32'h0);
    rd_chk(A_CTRL, 32'h30);
    isr_pulse(0);
    flag_chk(2'h0);
    wr(A_MODE, 32'h04);
    wr(A_T0H, 32'hFF);
    wr(A_T0L, 32'hFF);
    tmr_pin_model_i.pulse(0, 1);
    rd_chk(A_T0L, 32'hE0);
    rd_chk(A_T0H, 32'h0);
    flag_chk(2'h1);
    isr_pulse(0);
    for (int w = 0; w < 2; w++)
    begin
      wr(A_MODE, w ? 32'h60 : 32'h06);
      wr(w ? A_T1H : A_T0H, 32'h80);
      wr(w ? A_T1L : A_T0L, 32'hFF);
      wr(A_CTRL, w ? 32'h40 : 32'h10);
      tmr_pin_model_i.pulse(w, 1);
      rd_chk(w ? A_T1L : A_T0L, 32'h80);
      flag_chk(w ? 2'h2 : 2'h1);
      isr_pulse(w);
      flag_chk(2'h0);
    end
    // split mode with timer 1 used for counting only
    // High byte loaded last so no control write can wipe its overflow
    wr(A_MODE, 32'h67);
    wr(A_T0L, 32'h0);
    wr(A_CTRL, 32'h40);
    wr(A_T0H, 32'hFF);
    repeat (30) @(posedge core_clk_in);
    flag_chk(2'h2);
    rd_chk(A_T0L, 32'h0);
    wr(A_CTRL, 32'h10);
    tmr_pin_model_i.pulse(0, 2);
    rd_chk(A_T0L, 32'h02);
    rd_chk(A_CTRL, 32'h10);
    wr(A_MODE, 32'h70);
    wr(A_CTRL, 32'h40);
    tmr_pin_model_i.pulse(1, 1);
    rd_chk(A_T1L, 32'h80);
    final_report;
  end
endmodule // tmr_dual_timer_test

`default_nettype wire
